// ==== host_port_mirror_read_ctrl.sv ====
// read path of the external host port into the instruction ram mirror window
`timescale 1ns/1ps
`default_nettype none
module host_port_mirror_read_ctrl
  import host_port_pkg::*;
(
  input  wire logic               clk_i,              // system clock, 40 MHz
  input  wire logic               rst_i,              // async reset, active high
  // boot strap pins
  input  wire logic               boot_select_upper_i, // boot select, upper
  input  wire logic               boot_select_lower_i, // boot select, lower
  // external host parallel port
  input  wire logic               host_cs_n_i,        // host chip select, low active
  input  wire logic               host_rd_n_i,        // host read strobe, low active
  input  wire logic [HADDR_W-1:0] host_addr_i,        // host byte address
  output logic      [DATA_W-1:0]  host_data_o,        // read data to host
  output logic                    host_data_oe_o,     // data bus drive enable
  output logic                    host_ready_o,       // data valid, host may release
  output logic                    host_error_out_n_o, // host error pin, low active
  // internal bus read port toward instruction ram
  output logic                    mem_req_o,          // read request, held to ack
  output logic      [31:0]        mem_addr_o,         // word aligned internal address
  input  wire logic [DATA_W-1:0]  mem_rdata_i,        // read data, valid with ack
  input  wire logic               mem_ack_i,          // one cycle read acknowledge
  // register port
  input  wire logic [RADDR_W-1:0] reg_addr_i,         // register byte address
  input  wire logic [DATA_W-1:0]  reg_wdata_i,        // register write data
  input  wire logic               reg_wr_i,           // write strobe
  input  wire logic               reg_rd_i,           // read strobe
  output logic      [DATA_W-1:0]  reg_rdata_o,        // read data, cycle after strobe
  output logic                    irq_o               // level interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [3:0]         ctl_sync;
  logic [HADDR_W-1:0] addr_sync;

  // strobes reset to inactive so no phantom request appears after reset
  pin_sync #(
    .W       (4),
    .RST_VAL (4'h3)
  ) u_ctl_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({boot_select_upper_i, boot_select_lower_i, host_rd_n_i, host_cs_n_i}),
    .q_o   (ctl_sync)
  );

  // address bits may settle on different edges; the host holds the address
  // steady before the strobe, and the strobe takes as long to pass through
  pin_sync #(
    .W       (HADDR_W),
    .RST_VAL ('0)
  ) u_addr_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (host_addr_i),
    .q_o   (addr_sync)
  );

  logic       host_cs;
  logic       host_rd;
  boot_mode_t boot_mode;

  // straps are meant to be static; a change while a read is in flight
  // only takes effect at the next request
  assign host_cs   = ~ctl_sync[0];
  assign host_rd   = ~ctl_sync[1];
  assign boot_mode = boot_mode_t'(ctl_sync[3:2]);

  ////////////////////////////////////////////////////////////////////////////
  // line buffer

  line_buf_if lb ();

  line_buf u_line_buf (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .bus   (lb.mem)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    port_state_t             st;
    logic [DATA_W-1:0]       bus_ctrl;
    logic [DATA_W-1:0]       page_ctrl;
    logic [IRQ_W-1:0]        irq_stat;
    logic [IRQ_W-1:0]        irq_mask;
    logic [DATA_W-1:0]       rdata;
    logic                    req_seen;
    logic [HADDR_W-1:0]      addr;
    logic [TAG_W-1:0]        tag;
    logic                    tag_ok;
    logic [LAST_IDX:0]       valid;
    logic [IDX_W-1:0]        ptr;
    logic [IDX_W-1:0]        last;
    logic                    demand;
    logic [DATA_W-1:0]       data;
    logic                    err;
  } ctrl_state_t;

  ctrl_state_t s_r;
  ctrl_state_t s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  logic               pf_on;
  logic               page_on;
  logic               port_open;
  logic               host_req;
  logic               in_window;
  logic               in_tail;
  logic               hit;
  logic [TAG_W-1:0]   req_tag;
  logic [IDX_W-1:0]   req_idx;
  logic [HADDR_W-1:0] next_addr;
  logic [TAG_W-1:0]   next_tag;
  logic [IDX_W-1:0]   next_idx;
  logic               next_skip;
  logic               next_cached;
  logic [IRQ_W-1:0]   irq_set;

  assign pf_on   = s_r.bus_ctrl[BIT_PREFETCH];
  assign page_on = s_r.page_ctrl[BIT_PAGE_READ];

  // only the two mcu boot modes open the window; 00 disables the port
  // and 01 maps it to a reserved destination
  always_comb begin
    port_open = 1'b0;
    case (boot_mode)
      BOOT_EXT_MCU: port_open = 1'b1;
      BOOT_IRAM:    port_open = 1'b1;
      BOOT_SFLASH:  port_open = 1'b0;
      default:      port_open = 1'b0;
    endcase
  end

  assign host_req  = host_cs & host_rd;
  // window and tail tests use the synchronised address, which the host
  // holds steady for the whole read
  assign in_window = (addr_sync >= WIN_FIRST) && (addr_sync <= WIN_LAST);
  assign in_tail   = (addr_sync >= TAIL_FIRST) && in_window;
  assign req_tag   = addr_sync[HADDR_W-1:IDX_W+2];
  assign req_idx   = addr_sync[IDX_W+1:2];
  assign hit       = s_r.tag_ok && (s_r.tag == req_tag) && s_r.valid[req_idx];

  assign next_addr   = s_r.addr + 20'h00004;
  assign next_tag    = next_addr[HADDR_W-1:IDX_W+2];
  assign next_idx    = next_addr[IDX_W+1:2];
  // running ahead past the window end would touch memory behind it, so
  // the tail words are never fetched speculatively
  assign next_skip   = (next_addr >= TAIL_FIRST) || (next_addr < s_r.addr);
  assign next_cached = s_r.tag_ok && (s_r.tag == next_tag) && s_r.valid[next_idx];

  ////////////////////////////////////////////////////////////////////////////
  // next state
  // a read walks idle, fetch on a miss, then lookup, load and serve; the
  // buffer answers a cycle after its index is set, which is why lookup and
  // load are separate steps. serve holds ready and data until the
  // synchronised release is seen, and only after it may a prefetch start.
  // a request that lands while a prefetch runs is held in its pins and is
  // taken once the fetch has ended, trading a few cycles of latency for a
  // memory port that never has to abort a burst.

  always_comb begin
    s_nxt   = s_r;
    irq_set = '0;

    // a served or refused read re-arms only once the host lets go
    if (!host_req) begin
      s_nxt.req_seen = 1'b0;
    end

    case (s_r.st)
      ST_IDLE: begin
        if (host_req && !s_r.req_seen) begin
          s_nxt.req_seen = 1'b1;
          // refused reads never raise ready; the host has to time out
          if (!port_open || !in_window) begin
            irq_set[IRQ_REFUSED] = 1'b1;
          end else begin
            s_nxt.addr = {addr_sync[HADDR_W-1:2], 2'b00};
            if (in_tail && pf_on) begin
              s_nxt.err           = 1'b1;
              irq_set[IRQ_TAIL]   = 1'b1;
            end
            if (hit) begin
              s_nxt.st = ST_LOOKUP;
            end else begin
              if (!(s_r.tag_ok && (s_r.tag == req_tag))) begin
                s_nxt.valid = '0;
              end
              s_nxt.tag    = req_tag;
              s_nxt.tag_ok = 1'b1;
              s_nxt.ptr    = req_idx;
              s_nxt.last   = page_on ? LAST_IDX : req_idx;
              s_nxt.demand = 1'b1;
              s_nxt.st     = ST_FETCH;
            end
          end
        end
      end

      // page reads walk the line up to its last word; single reads stop
      // after the word that was asked for
      ST_FETCH: begin
        if (mem_ack_i) begin
          s_nxt.valid[s_r.ptr] = 1'b1;
          if (s_r.ptr == s_r.last) begin
            s_nxt.st = s_r.demand ? ST_LOOKUP : ST_IDLE;
          end else begin
            s_nxt.ptr = s_r.ptr + 2'h1;
          end
        end
      end

      // lookup only gives the buffer a cycle to present the word
      ST_LOOKUP: begin
        s_nxt.st = ST_LOAD;
      end

      // buffer read data is registered, so it is taken one cycle later
      ST_LOAD: begin
        s_nxt.data = lb.rdata;
        s_nxt.st   = ST_SERVE;
      end

      ST_SERVE: begin
        if (!host_req) begin
          // error falls with the release so the pin covers the whole read
          s_nxt.err = 1'b0;
          s_nxt.st  = ST_IDLE;
          // with prefetch off no fetch starts after a release; only a page read takes words past the one asked for
          if (pf_on && !next_skip && !next_cached) begin
            if (next_tag != s_r.tag) begin
              s_nxt.valid = '0;
            end
            s_nxt.tag    = next_tag;
            s_nxt.ptr    = next_idx;
            s_nxt.last   = page_on ? LAST_IDX : next_idx;
            s_nxt.demand = 1'b0;
            s_nxt.st     = ST_FETCH;
          end
        end
      end

      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase

    // register writes; a hardware set wins over a software clear
    if (reg_wr_i) begin
      if (reg_addr_i == OFS_BUS_CTRL) begin
        s_nxt.bus_ctrl = reg_wdata_i;
      end else if (reg_addr_i == OFS_PAGE_CTRL) begin
        s_nxt.page_ctrl = reg_wdata_i;
      end else if (reg_addr_i == OFS_IRQ_STAT) begin
        s_nxt.irq_stat = s_r.irq_stat & ~reg_wdata_i[IRQ_W-1:0];
      end else if (reg_addr_i == OFS_IRQ_MASK) begin
        s_nxt.irq_mask = reg_wdata_i[IRQ_W-1:0];
      end
    end
    s_nxt.irq_stat = s_nxt.irq_stat | irq_set;

    // register reads; unmapped offsets read zero
    s_nxt.rdata = '0;
    if (reg_rd_i) begin
      if (reg_addr_i == OFS_BUS_CTRL) begin
        s_nxt.rdata = s_r.bus_ctrl;
      end else if (reg_addr_i == OFS_PAGE_CTRL) begin
        s_nxt.rdata = s_r.page_ctrl;
      end else if (reg_addr_i == OFS_IRQ_STAT) begin
        s_nxt.rdata = {30'h0, s_r.irq_stat};
      end else if (reg_addr_i == OFS_IRQ_MASK) begin
        s_nxt.rdata = {30'h0, s_r.irq_mask};
      end else if (reg_addr_i == OFS_PORT_STAT) begin
        s_nxt.rdata = {24'h0, s_r.st, port_open, boot_mode};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  // control registers come up with prefetch off and single reads, so a host
  // that reads before software runs sees plain on-demand behaviour

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r           <= '0;
      s_r.st        <= ST_IDLE;
      s_r.bus_ctrl  <= RST_BUS_CTRL;
      s_r.page_ctrl <= RST_PAGE_CTRL;
      s_r.irq_stat  <= RST_IRQ;
      s_r.irq_mask  <= RST_IRQ;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // buffer ports and outputs

  // the buffer is written straight from the memory port on the ack cycle;
  // its read index follows the accepted host address
  assign lb.we    = (s_r.st == ST_FETCH) && mem_ack_i;
  assign lb.widx  = s_r.ptr;
  assign lb.wdata = mem_rdata_i;
  assign lb.ridx  = s_r.addr[IDX_W+1:2];

  // request and address come from state, so both hold until the ack
  assign mem_req_o  = (s_r.st == ST_FETCH);
  // window offset maps one to one onto the internal bus range
  assign mem_addr_o = AHB_BASE | {12'h000, s_r.tag, s_r.ptr, 2'b00};

  assign host_data_o        = s_r.data;
  assign host_data_oe_o     = (s_r.st == ST_SERVE);
  assign host_ready_o       = (s_r.st == ST_SERVE);
  assign host_error_out_n_o = ~s_r.err;

  assign reg_rdata_o = s_r.rdata;
  // level interrupt: stays high until software clears the status bit
  assign irq_o       = |(s_r.irq_stat & s_r.irq_mask);

endmodule
`default_nettype wire

// ==== host_port_pkg.sv ====
// shared constants and types for the host port mirror read controller
`default_nettype none
package host_port_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int HADDR_W   = 20;
  localparam int DATA_W    = 32;
  localparam int RADDR_W   = 8;
  localparam int IDX_W     = 2;
  localparam int TAG_W     = HADDR_W - IDX_W - 2;
  localparam int IRQ_W     = 2;

  ////////////////////////////////////////////////////////////////////////////
  // mirror window, host side and internal bus side
  localparam logic [HADDR_W-1:0] WIN_FIRST  = 20'h00000;
  localparam logic [HADDR_W-1:0] WIN_LAST   = 20'hbffff;
  localparam logic [31:0]        AHB_BASE   = 32'h0000_0000;
  localparam logic [HADDR_W-1:0] TAIL_BYTES = 20'h00010;
  localparam logic [HADDR_W-1:0] TAIL_FIRST = WIN_LAST - TAIL_BYTES + 20'h00001;
  localparam logic [IDX_W-1:0]   LAST_IDX   = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets, field positions, reset values
  localparam logic [RADDR_W-1:0] OFS_BUS_CTRL  = 8'h00;
  localparam logic [RADDR_W-1:0] OFS_PAGE_CTRL = 8'h04;
  localparam logic [RADDR_W-1:0] OFS_IRQ_STAT  = 8'h08;
  localparam logic [RADDR_W-1:0] OFS_IRQ_MASK  = 8'h0c;
  localparam logic [RADDR_W-1:0] OFS_PORT_STAT = 8'h10;
  localparam int                 BIT_PREFETCH  = 1;
  localparam int                 BIT_PAGE_READ = 1;
  localparam int                 IRQ_TAIL      = 0;
  localparam int                 IRQ_REFUSED   = 1;
  localparam logic [DATA_W-1:0]  RST_BUS_CTRL  = 32'h0000_0000;
  localparam logic [DATA_W-1:0]  RST_PAGE_CTRL = 32'h0000_0000;
  localparam logic [IRQ_W-1:0]   RST_IRQ       = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // enumerations
  typedef enum logic [1:0] {
    BOOT_EXT_MEM = 2'h0,
    BOOT_SFLASH  = 2'h1,
    BOOT_EXT_MCU = 2'h2,
    BOOT_IRAM    = 2'h3
  } boot_mode_t;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_FETCH  = 5'h02,
    ST_LOOKUP = 5'h04,
    ST_LOAD   = 5'h08,
    ST_SERVE  = 5'h10
  } port_state_t;

endpackage
`default_nettype wire

// ==== line_buf_if.sv ====
// carrier between the controller and its read line buffer
`timescale 1ns/1ps
`default_nettype none
interface line_buf_if;
  import host_port_pkg::*;
  logic              we;
  logic [IDX_W-1:0]  widx;
  logic [DATA_W-1:0] wdata;
  logic [IDX_W-1:0]  ridx;
  logic [DATA_W-1:0] rdata;
  modport ctrl (output we, output widx, output wdata, output ridx, input rdata);
  modport mem  (input we, input widx, input wdata, input ridx, output rdata);
endinterface
`default_nettype wire

// ==== pin_sync.sv ====
// two flip-flop synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import host_port_pkg::*;
#(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_i,  // system clock
  input  wire logic         rst_i,  // async reset, active high
  input  wire logic [W-1:0] d_i,    // asynchronous input
  output logic      [W-1:0] q_o     // synchronised output
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_state_t;

  sync_state_t s_r;
  sync_state_t s_nxt;

  always_comb begin
    s_nxt        = s_r;
    s_nxt.meta   = d_i;
    s_nxt.stable = s_r.meta;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '{meta: RST_VAL, stable: RST_VAL};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q_o = s_r.stable;
endmodule
`default_nettype wire

// ==== line_buf.sv ====
// four word read line buffer with registered read data
`timescale 1ns/1ps
`default_nettype none
module line_buf
  import host_port_pkg::*;
(
  input  wire logic clk_i,  // system clock
  input  wire logic rst_i,  // async reset, active high
  line_buf_if.mem   bus     // write and read ports
);
  typedef struct packed {
    logic [LAST_IDX:0][DATA_W-1:0] word;
    logic [DATA_W-1:0]             rdata;
  } buf_state_t;

  buf_state_t s_r;
  buf_state_t s_nxt;

  always_comb begin
    s_nxt       = s_r;
    s_nxt.rdata = s_r.word[bus.ridx];
    if (bus.we) begin
      s_nxt.word[bus.widx] = bus.wdata;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.rdata = s_r.rdata;
endmodule
`default_nettype wire

// ==== host_port_chk_sva.sv ====
// port assertions for the host port mirror read controller
`timescale 1ns/1ps
`default_nettype none
module host_port_chk
  import host_port_pkg::*;
(
  input wire logic               clk_i,               // clock
  input wire logic               rst_i,               // reset
  input wire logic               boot_select_upper_i, // boot upper
  input wire logic               host_cs_n_i,         // select
  input wire logic               host_rd_n_i,         // strobe
  input wire logic [HADDR_W-1:0] host_addr_i,         // address
  input wire logic               host_ready_o,        // ready
  input wire logic               host_error_out_n_o,  // error pin
  input wire logic               mem_req_o,           // fetch
  input wire logic [31:0]        mem_addr_o,          // fetch addr
  input wire logic               mem_ack_i,           // fetch ack
  input wire logic [RADDR_W-1:0] reg_addr_i,          // reg addr
  input wire logic [DATA_W-1:0]  reg_wdata_i,         // reg data
  input wire logic               reg_wr_i,            // write
  input wire logic               reg_rd_i,            // read
  input wire logic [DATA_W-1:0]  reg_rdata_o          // read data
);
  logic pf_r;
  logic pg_r;
  logic tail;
  // shadow of the two mode bits, kept from the register writes
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pf_r <= 1'b0;
      pg_r <= 1'b0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == OFS_BUS_CTRL) pf_r <= reg_wdata_i[BIT_PREFETCH];
      if (reg_addr_i == OFS_PAGE_CTRL) pg_r <= reg_wdata_i[BIT_PAGE_READ];
    end
  end
  assign tail = host_addr_i >= TAIL_FIRST && host_addr_i <= WIN_LAST;
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence served_s;
    $rose(host_ready_o);
  endsequence
  sequence taken_s;
    mem_req_o && mem_ack_i;
  endsequence
  ready_boot_a: assert property (served_s |-> boot_select_upper_i)
    else $error("host served while port closed");
  ready_range_a: assert property (served_s |-> host_addr_i <= WIN_LAST)
    else $error("host served outside window");
  mem_range_a: assert property (mem_req_o |-> mem_addr_o <= 32'h000b_ffff)
    else $error("fetch outside window");
  mem_hold_a: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
    else $error("fetch dropped before ack");
  err_tail_a: assert property (served_s ##0 (pf_r && tail) |-> !host_error_out_n_o)
    else $error("tail read without error");
  err_quiet_a: assert property (served_s ##0 !(pf_r && tail) |-> host_error_out_n_o)
    else $error("error on plain read");
  on_demand_a: assert property ($rose(mem_req_o) && !pf_r |-> !host_cs_n_i && !host_rd_n_i)
    else $error("speculative fetch with prefetch off");
  pf_skip_a: assert property ($rose(mem_req_o) && host_cs_n_i |-> mem_addr_o < 32'h000b_fff0)
    else $error("prefetch into tail");
  page_burst_a: assert property (taken_s ##0 (pg_r && mem_addr_o[3:2] != 2'h3)
    |=> mem_req_o && mem_addr_o == $past(mem_addr_o) + 32'h4)
    else $error("page burst broken");
  single_word_a: assert property (taken_s ##0 !pg_r |=> !mem_req_o)
    else $error("burst in single read mode");
  cfg_read_a: assert property (reg_rd_i && reg_addr_i == OFS_BUS_CTRL
    |=> reg_rdata_o[BIT_PREFETCH] == $past(pf_r))
    else $error("prefetch bit readback");
endmodule
bind host_port_mirror_read_ctrl host_port_chk host_port_chk_inst (.clk_i, .rst_i,
  .boot_select_upper_i, .host_cs_n_i, .host_rd_n_i, .host_addr_i, .host_ready_o,
  .host_error_out_n_o, .mem_req_o, .mem_addr_o, .mem_ack_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .reg_rd_i, .reg_rdata_o);
`default_nettype wire

// ==== iram_model.sv ====
// instruction ram model on the internal read port
`timescale 1ns/1ps
`default_nettype none
module iram_model (
  input  wire logic        clk_i,   // clock
  input  wire logic        rst_i,   // reset
  input  wire logic        req_i,   // read request
  input  wire logic [31:0] addr_i,  // word address
  input  wire logic [1:0]  delay_i, // wait cycles
  output logic      [31:0] rdata_o, // read data
  output logic             ack_o    // acknowledge
);
  logic [1:0] wait_r;
  // data follows the address, so a misrouted fetch shows as wrong data
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o   <= 1'b0;
      wait_r  <= 2'h0;
      rdata_o <= 32'h0;
    end else if (req_i && !ack_o && wait_r == delay_i) begin
      ack_o   <= 1'b1;
      wait_r  <= 2'h0;
      rdata_o <= {12'h3c5, addr_i[19:2], 2'h0};
    end else begin
      ack_o   <= 1'b0;
      wait_r  <= (req_i && !ack_o) ? wait_r + 2'h1 : 2'h0;
      rdata_o <= ~rdata_o;
    end
  end
endmodule
`default_nettype wire

// ==== test_host_port_mirror_read_ctrl.sv ====
// self-checking bench for the host port mirror read controller
`timescale 1ns/1ps
`default_nettype none
module test_host_port_mirror_read_ctrl;
  import host_port_pkg::*;
  logic               clk_i = 1'b0;
  logic               rst_i = 1'b1;
  logic               boot_select_upper_i = 1'b1;
  logic               boot_select_lower_i = 1'b0;
  logic               host_cs_n_i = 1'b1;
  logic               host_rd_n_i = 1'b1;
  logic [HADDR_W-1:0] host_addr_i = '0;
  logic [RADDR_W-1:0] reg_addr_i = '0;
  logic [DATA_W-1:0]  reg_wdata_i = '0;
  logic               reg_wr_i = 1'b0;
  logic               reg_rd_i = 1'b0;
  logic [1:0]         dly = 2'h0;
  logic [DATA_W-1:0]  host_data_o, reg_rdata_o, mem_rdata_i, hdata;
  logic [31:0]        mem_addr_o;
  logic               host_data_oe_o, host_ready_o, host_error_out_n_o, herr, hoe;
  logic               mem_req_o, mem_ack_i, irq_o;
  int                 fails = 0;
  int                 n_tests = 0;
  always #12.5 clk_i = ~clk_i;
  host_port_mirror_read_ctrl host_port_mirror_read_ctrl_inst (.clk_i, .rst_i,
    .boot_select_upper_i, .boot_select_lower_i, .host_cs_n_i, .host_rd_n_i, .host_addr_i,
    .host_data_o, .host_data_oe_o, .host_ready_o, .host_error_out_n_o, .mem_req_o,
    .mem_addr_o, .mem_rdata_i, .mem_ack_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .irq_o);
  iram_model iram_model_inst (.clk_i, .rst_i, .req_i(mem_req_o), .addr_i(mem_addr_o),
    .delay_i(dly), .rdata_o(mem_rdata_i), .ack_o(mem_ack_i));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] exp_word(input logic [19:0] a);
    return {12'h3c5, a[19:2], 2'h0};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(posedge clk_i);
    d = reg_rdata_o;
  endtask
  // a refused read never gets ready, so the host gives up after 40 cycles
  task automatic host_rd(input logic [19:0] a, output logic ok);
    ok = 1'b0;
    @(posedge clk_i);
    host_cs_n_i <= 1'b0;
    host_rd_n_i <= 1'b0;
    host_addr_i <= a;
    for (int i = 0; i < 40 && !ok; i++) begin
      @(posedge clk_i);
      ok = host_ready_o === 1'b1;
    end
    hdata = host_data_o;
    herr  = host_error_out_n_o;
    hoe   = host_data_oe_o;
    host_cs_n_i <= 1'b1;
    host_rd_n_i <= 1'b1;
    host_addr_i <= ~a;
    repeat (24) @(posedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    logic        ok;
    logic [31:0] d;
    logic [19:0] a;
    logic [1:0]  m;
    logic [7:0]  ofs [5];
    logic [19:0] corner [4];
    ofs = '{OFS_BUS_CTRL, OFS_PAGE_CTRL, OFS_IRQ_STAT, OFS_IRQ_MASK, 8'h40};
    corner = '{20'h00000, 20'hbffec, 20'hbfff0, 20'hbfffc};
    void'($urandom(27));
    fork
      begin
        #(20000 * 25);
        fails++;
        close_out();
      end
    join_none
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ofs[i]) begin
      reg_rd(ofs[i], d);
      check("reset value", d, 32'h0);
    end
    reg_wr(OFS_IRQ_MASK, 32'h3);
    for (int b = 0; b < 4; b++) begin
      m = b[1:0];
      {boot_select_upper_i, boot_select_lower_i} <= m;
      repeat (4) @(posedge clk_i);
      reg_rd(OFS_PORT_STAT, d);
      check("boot status", d[2:0], {m[1], m});
      reg_wr(OFS_IRQ_STAT, 32'h3);
      host_rd(20'h00104, ok);
      check("host answered", ok, m[1]);
      check("refused drive", hoe, m[1]);
      if (ok) check("boot data", hdata, exp_word(20'h00104));
      check("refused irq", irq_o, !m[1]);
    end
    {boot_select_upper_i, boot_select_lower_i} <= 2'h2;
    reg_wr(OFS_IRQ_STAT, 32'h3);
    reg_wr(OFS_IRQ_MASK, 32'h1);
    host_rd(20'hc0000, ok);
    check("out of window", ok, 1'b0);
    reg_rd(OFS_IRQ_STAT, d);
    check("refused status", d, 32'h2);
    check("masked irq", irq_o, 1'b0);
    reg_wr(OFS_IRQ_MASK, 32'h3);
    repeat (2) @(posedge clk_i);
    check("unmasked irq", irq_o, 1'b1);
    reg_wr(OFS_IRQ_STAT, 32'h2);
    repeat (2) @(posedge clk_i);
    check("cleared irq", irq_o, 1'b0);
    for (int md = 0; md < 4; md++) begin
      reg_wr(OFS_BUS_CTRL, {30'h0, md[1], 1'b0});
      reg_wr(OFS_PAGE_CTRL, {30'h0, md[0], 1'b0});
      reg_rd(OFS_BUS_CTRL, d);
      check("prefetch bit", d, {30'h0, md[1], 1'b0});
      for (int i = 0; i < 12; i++) begin
        a = (i < 4) ? corner[i] : 20'($urandom_range(32'hbffff));
        dly <= 2'($urandom_range(3));
        host_rd(a, ok);
        check("window read", ok, 1'b1);
        check("read data", hdata, exp_word(a));
        check("error pin", herr, !(md[1] && a >= TAIL_FIRST));
        check("data drive", hoe, 1'b1);
        check("drive released", host_data_oe_o, 1'b0);
      end
      reg_rd(OFS_IRQ_STAT, d);
      check("tail status", d[0], md[1]);
      reg_wr(OFS_IRQ_STAT, 32'h1);
    end
    close_out();
  end
endmodule
`default_nettype wire
